// ===== rtl/temp_loop_operation_data.sv
// Per-loop operation-data exchange of a two-loop temperature controller.
`timescale 1ns/100ps

module temp_loop_channel
  import temp_loop_pkg::*;
#(
  parameter logic signed [15:0] PV_LOW = PV_LOW_DEFAULT,
  parameter logic signed [15:0] PV_HIGH = PV_HIGH_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic refresh,
  input temp_loop_pkg::host_out_t host_out,
  output temp_loop_pkg::host_in_t host_in,
  input wire logic signed [15:0] pv_measured,
  input wire logic [15:0] current_measured,
  input wire logic heater_on,
  input wire logic tune_finish,
  input temp_loop_pkg::pid_t tuned_pid,
  input temp_loop_pkg::pid_t host_pid,
  input wire logic halt_ignored,
  input wire logic persist_finish,
  output logic control_run,
  output logic autotuning,
  output logic burnout_out,
  output temp_loop_pkg::pid_t working_pid,
  output logic persist_req,
  output temp_loop_pkg::persist_t persist_data
);

  // ---------------------------------------------------------------
  // State and decoded events
  // ---------------------------------------------------------------
  loop_state_t s_q; // Registered state of this loop
  loop_state_t s_d; // Next state

  logic pv_fault;      // Process value outside indication range
  logic cur_over;      // Heater current above limit
  logic begin_edge;    // Rising edges seen at this refresh
  logic abort_edge;
  logic reload_edge;
  logic persist_edge;
  logic hb_detect;     // Heater burnout condition

  // ---------------------------------------------------------------
  // Measurement checks
  // ---------------------------------------------------------------
  // Range checks run every cycle; the report only samples them at refresh
  always_comb begin
    pv_fault = (pv_measured < PV_LOW) || (pv_measured > PV_HIGH);
    cur_over = current_measured > CURRENT_LIMIT;
  end

  // ---------------------------------------------------------------
  // Command edge detection
  // ---------------------------------------------------------------
  // Compare with the copy from the previous refresh, so a command held high
  // over many refreshes acts only once
  always_comb begin
    begin_edge = refresh && host_out.autotune_begin_request
                 && !s_q.cfg.autotune_begin_request;
    abort_edge = refresh && host_out.autotune_abort_request
                 && !s_q.cfg.autotune_abort_request;
    reload_edge = refresh && host_out.pid_reload_request
                  && !s_q.cfg.pid_reload_request;
    persist_edge = refresh && host_out.settings_persist_request
                   && !s_q.cfg.settings_persist_request;
  end

  // ---------------------------------------------------------------
  // Heater burnout
  // ---------------------------------------------------------------
  // Burnout means the current fails to exceed the threshold while heating
  always_comb begin
    if (s_q.cfg.burnout_threshold_config == BURNOUT_FORCED) begin
      hb_detect = 1'b1;
    end else if (s_q.cfg.burnout_threshold_config == BURNOUT_OFF) begin
      hb_detect = 1'b0;
    end else begin
      hb_detect = heater_on && !cur_over
                  && (current_measured <= s_q.cfg.burnout_threshold_config);
    end
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.burnout = hb_detect;

    // Host variables are taken only at refresh; only read/write ones exist
    if (refresh) begin
      s_d.cfg = host_out;
    end

    // Halt follows the level, unless the switch and host mode mask it
    if (halt_ignored) begin
      s_d.halted = 1'b0;
    end else if (refresh) begin
      s_d.halted = host_out.control_halt_request;
    end

    // Autotuning: a finish clears it, begin starts it, abort only if running
    if (tune_finish && s_q.autotuning) begin
      s_d.autotuning = 1'b0;
    end
    if (begin_edge) begin
      s_d.autotuning = 1'b1;
    end
    if (abort_edge && s_q.autotuning) begin
      s_d.autotuning = 1'b0;
    end

    // Reload first, so a finish in the same cycle still sets the flag
    if (reload_edge) begin
      s_d.tune_ready = 1'b0;
      s_d.work_pid = host_pid;
    end
    if (tune_finish && s_q.autotuning) begin
      s_d.tune_ready = 1'b1;
      s_d.work_pid = tuned_pid;
    end

    // Non-volatile write; a second request while busy is dropped
    unique case (s_q.pst)
      PS_IDLE: begin
        if (persist_edge) begin
          s_d.pst = PS_WRITE;
          s_d.persist_done = 1'b0;
          s_d.payload.setpoint = s_q.cfg.setpoint_config;
          s_d.payload.burnout_threshold = s_q.cfg.burnout_threshold_config;
          s_d.payload.pid = s_q.work_pid;
        end
      end
      PS_WRITE: begin
        // Storage busy: hold request and payload stable
        if (persist_finish) begin
          s_d.pst = PS_IDLE;
          s_d.persist_done = 1'b1;
        end
      end
    endcase

    // Report built from the values taking effect now
    if (refresh) begin
      s_d.rpt.process_value_monitor = pv_fault ? OVER_SENTINEL
                                               : pv_measured;
      s_d.rpt.heater_current_monitor = cur_over ? OVER_SENTINEL
                                                : current_measured;
      s_d.rpt.setpoint_monitor = s_d.cfg.setpoint_config;
      s_d.rpt.burnout_threshold_monitor =
        s_d.cfg.burnout_threshold_config;
      s_d.rpt.loop_status_word = 16'h0000;
      s_d.rpt.loop_status_word[ST_BURNOUT] = hb_detect;
      s_d.rpt.loop_status_word[ST_AUTOTUNING] = s_d.autotuning;
      s_d.rpt.loop_status_word[ST_RUNNING] = !s_d.halted;
      s_d.rpt.loop_status_word[ST_HALTED] = s_d.halted;
      s_d.rpt.loop_status_word[ST_OVERRANGE] = cur_over;
      s_d.rpt.loop_status_word[ST_INPUT_FAULT] = pv_fault;
      s_d.rpt.loop_status_word[ST_PERSIST_DONE] = s_d.persist_done;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.cfg.setpoint_config <= RST_SETPOINT;
      s_q.cfg.burnout_threshold_config <= RST_BURNOUT;
      s_q.rpt.setpoint_monitor <= RST_SETPOINT;
      s_q.rpt.burnout_threshold_monitor <= RST_BURNOUT;
      s_q.halted <= RST_HALTED;
      s_q.pst <= PS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All from flip-flops; the controller core reads these directly
  always_comb begin
    host_in = s_q.rpt;
    control_run = !s_q.halted;
    autotuning = s_q.autotuning;
    burnout_out = s_q.burnout;
    working_pid = s_q.work_pid;
    persist_req = (s_q.pst == PS_WRITE);
    persist_data = s_q.payload;
  end

endmodule : temp_loop_channel

// ---------------------------------------------------------------
// Top: one channel per loop
// ---------------------------------------------------------------
module temp_loop_operation_data
  import temp_loop_pkg::*;
#(
  parameter int unsigned LOOPS = LOOP_COUNT,
  parameter logic signed [15:0] PV_LOW = PV_LOW_DEFAULT,
  parameter logic signed [15:0] PV_HIGH = PV_HIGH_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic refresh,
  input temp_loop_pkg::host_out_t [LOOPS-1:0] host_out,
  output temp_loop_pkg::host_in_t [LOOPS-1:0] host_in,
  input wire logic [LOOPS-1:0][15:0] pv_measured,
  input wire logic [LOOPS-1:0][15:0] current_measured,
  input wire logic [LOOPS-1:0] heater_on,
  input wire logic [LOOPS-1:0] tune_finish,
  input temp_loop_pkg::pid_t [LOOPS-1:0] tuned_pid,
  input temp_loop_pkg::pid_t [LOOPS-1:0] host_pid,
  input wire logic dip_pin1_on,
  input wire logic host_program_mode,
  input wire logic [LOOPS-1:0] persist_finish,
  output logic [LOOPS-1:0] control_run,
  output logic [LOOPS-1:0] autotuning,
  output logic [LOOPS-1:0] burnout_out,
  output temp_loop_pkg::pid_t [LOOPS-1:0] working_pid,
  output logic [LOOPS-1:0] persist_req,
  output temp_loop_pkg::persist_t [LOOPS-1:0] persist_data
);

  logic halt_ignored; // Shared mask of the halt command

  // Switch off and host in program mode masks every loop's halt
  assign halt_ignored = !dip_pin1_on && host_program_mode;

  // Each loop owns a separate channel, so nothing leaks between loops
  for (genvar g = 0; g < LOOPS; g++) begin : g_loop
    temp_loop_channel #(
      .PV_LOW(PV_LOW),
      .PV_HIGH(PV_HIGH)
    ) u_channel (
      .clk(clk),
      .resetn(resetn),
      .refresh(refresh),
      .host_out(host_out[g]),
      .host_in(host_in[g]),
      .pv_measured(signed'(pv_measured[g])),
      .current_measured(current_measured[g]),
      .heater_on(heater_on[g]),
      .tune_finish(tune_finish[g]),
      .tuned_pid(tuned_pid[g]),
      .host_pid(host_pid[g]),
      .halt_ignored(halt_ignored),
      .persist_finish(persist_finish[g]),
      .control_run(control_run[g]),
      .autotuning(autotuning[g]),
      .burnout_out(burnout_out[g]),
      .working_pid(working_pid[g]),
      .persist_req(persist_req[g]),
      .persist_data(persist_data[g])
    );
  end

endmodule : temp_loop_operation_data

// ===== rtl/temp_loop_pkg.sv
// Shared types and constants of the two-loop operation-data exchange.
package temp_loop_pkg;

  // ---------------------------------------------------------------
  // Loop count and data widths
  // ---------------------------------------------------------------
  localparam int unsigned LOOP_COUNT = 2; // Two independent loops
  localparam int unsigned WORD_W = 16;    // Every exchanged word is 16 bits

  // ---------------------------------------------------------------
  // Fixed values (tenths of a unit)
  // ---------------------------------------------------------------
  localparam logic [15:0] OVER_SENTINEL = 16'hcccc;   // -13,108 as a 16-bit word
  localparam logic [15:0] CURRENT_LIMIT = 16'h0226;   // 55.0 A
  localparam logic [15:0] BURNOUT_OFF = 16'h0000;     // 0.0 disables detection
  localparam logic [15:0] BURNOUT_FORCED = 16'h01f4;  // 50.0 forces output on
  localparam logic signed [15:0] PV_LOW_DEFAULT = 16'sh8000;  // Lowest indication
  localparam logic signed [15:0] PV_HIGH_DEFAULT = 16'sh7fff; // Highest indication

  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int unsigned ST_BURNOUT = 2;      // Heater burnout detected
  localparam int unsigned ST_AUTOTUNING = 3;   // Autotuning in progress
  localparam int unsigned ST_RUNNING = 4;      // Control output active
  localparam int unsigned ST_HALTED = 8;       // Control stopped
  localparam int unsigned ST_OVERRANGE = 13;   // Heater current over range
  localparam int unsigned ST_INPUT_FAULT = 14; // Process value out of range
  localparam int unsigned ST_PERSIST_DONE = 15; // Non-volatile write complete

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_SETPOINT = 16'h0000; // Set point in effect
  localparam logic [15:0] RST_BURNOUT = 16'h0000;  // Detection off until written
  localparam logic RST_HALTED = 1'b1;              // No control before first refresh unless the halt is masked

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Host-to-module variables of one loop, read/write for the host
  typedef struct packed {
    logic [15:0] setpoint_config;
    logic [15:0] burnout_threshold_config;
    logic autotune_begin_request;
    logic autotune_abort_request;
    logic control_halt_request;
    logic pid_reload_request;
    logic settings_persist_request;
  } host_out_t;

  // Module-to-host variables of one loop, read-only for the host
  typedef struct packed {
    logic [15:0] process_value_monitor;
    logic [15:0] heater_current_monitor;
    logic [15:0] setpoint_monitor;
    logic [15:0] burnout_threshold_monitor;
    logic [15:0] loop_status_word;
  } host_in_t;

  // One set of PID constants
  typedef struct packed {
    logic [15:0] prop_band;
    logic [15:0] integral_time;
    logic [15:0] derivative_time;
  } pid_t;

  // Payload handed to non-volatile storage
  typedef struct packed {
    logic [15:0] setpoint;
    logic [15:0] burnout_threshold;
    pid_t pid;
  } persist_t;

  // Non-volatile write sequencer
  typedef enum logic {
    PS_IDLE,
    PS_WRITE
  } persist_state_t;

  // Whole state of one loop
  typedef struct packed {
    host_out_t cfg;          // Last refreshed host variables
    host_in_t rpt;           // Values shown to the host
    logic autotuning;
    logic tune_ready;        // Constants calculated flag
    logic persist_done;
    logic halted;
    logic burnout;
    pid_t work_pid;          // Working copy used by control
    persist_state_t pst;
    persist_t payload;
  } loop_state_t;

endpackage : temp_loop_pkg

// ===== verif/host_refresh_model.sv
// Host model: paces the controller's I/O refresh strobe.
`timescale 1ns/100ps

module host_refresh_model #(
  parameter int GAP = 5 // Cycles per host cycle
) (
  input wire logic clk,
  input wire logic resetn,
  output logic refresh
);
  // ---------------------------------------------------------------
  // Refresh pacing
  // ---------------------------------------------------------------
  int cnt_q; // Cycles since the last strobe
  // One strobe per host cycle, none while in reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 0;
      refresh <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      refresh <= (cnt_q == GAP - 1);
    end
  end
endmodule : host_refresh_model

// ===== verif/temp_loop_operation_data_asserts.sv
// Checker of the host exchange and loop commands, bound to the top module.
`timescale 1ns/100ps

module temp_loop_operation_data_asserts
  import temp_loop_pkg::*;
#(
  parameter int unsigned LOOPS = LOOP_COUNT,
  parameter logic signed [15:0] PV_LOW = PV_LOW_DEFAULT,
  parameter logic signed [15:0] PV_HIGH = PV_HIGH_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic refresh,
  input temp_loop_pkg::host_out_t [LOOPS-1:0] host_out,
  input temp_loop_pkg::host_in_t [LOOPS-1:0] host_in,
  input wire logic [LOOPS-1:0][15:0] pv_measured,
  input wire logic [LOOPS-1:0][15:0] current_measured,
  input wire logic dip_pin1_on,
  input wire logic host_program_mode,
  input wire logic [LOOPS-1:0] persist_finish,
  input wire logic [LOOPS-1:0] control_run,
  input wire logic [LOOPS-1:0] autotuning,
  input wire logic [LOOPS-1:0] burnout_out,
  input wire logic [LOOPS-1:0] persist_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // Helper: command bits of loop 0 at the previous refresh
  // ---------------------------------------------------------------
  logic begin_q;
  logic abort_q;
  // Edge detection needs the last refreshed value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      begin_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (refresh) begin
      begin_q <= host_out[0].autotune_begin_request;
      abort_q <= host_out[0].autotune_abort_request;
    end
  end
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence s_begin_edge;
    refresh && host_out[0].autotune_begin_request && !begin_q && !autotuning[0];
  endsequence
  sequence s_abort_edge;
    refresh && host_out[0].autotune_abort_request && !abort_q && autotuning[0];
  endsequence
  sequence s_write_end;
    persist_req[0] && persist_finish[0];
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_PV_FAULT: assert property (
    refresh && $signed(pv_measured[0]) > PV_HIGH |=>
    host_in[0].process_value_monitor == 16'hcccc && host_in[0].loop_status_word[14])
    else $error("pv fault not reported");
  AST_CUR_OVER: assert property (
    refresh && current_measured[0] > 16'h0226 |=>
    host_in[0].heater_current_monitor == 16'hcccc && host_in[0].loop_status_word[13])
    else $error("current overrange not reported");
  AST_SP_MIRROR: assert property (
    refresh |=> host_in[0].setpoint_monitor == $past(host_out[0].setpoint_config))
    else $error("setpoint monitor wrong");
  AST_BURN_FORCED: assert property (
    host_in[0].burnout_threshold_monitor == 16'h01f4 |=> burnout_out[0])
    else $error("forced burnout output off");
  AST_BURN_OFF: assert property (
    host_in[0].burnout_threshold_monitor == 16'h0000 |=> !burnout_out[0])
    else $error("burnout seen while disabled");
  AST_BEGIN: assert property (
    s_begin_edge |=> autotuning[0])
    else $error("autotuning did not begin");
  AST_ABORT: assert property (
    s_abort_edge |=> !autotuning[0])
    else $error("autotuning not aborted");
  AST_HALT: assert property (
    refresh && (dip_pin1_on || !host_program_mode) |=>
    control_run[0] == !$past(host_out[0].control_halt_request))
    else $error("halt request not followed");
  AST_HALT_IGNORED: assert property (
    !dip_pin1_on && host_program_mode |=> control_run[0])
    else $error("halt acted while ignored");
  AST_PERSIST_END: assert property (
    s_write_end |=> !persist_req[0])
    else $error("write request not dropped");
  AST_DONE_SHOWN: assert property (
    s_write_end ##[2:8] (refresh && !host_out[0].settings_persist_request) |=>
    host_in[0].loop_status_word[15])
    else $error("persist done not shown");
endmodule : temp_loop_operation_data_asserts

bind temp_loop_operation_data temp_loop_operation_data_asserts #(
  .LOOPS(LOOPS), .PV_LOW(PV_LOW), .PV_HIGH(PV_HIGH)) chk_u (
  .clk(clk), .resetn(resetn), .refresh(refresh), .host_out(host_out), .host_in(host_in),
  .pv_measured(pv_measured), .current_measured(current_measured),
  .dip_pin1_on(dip_pin1_on), .host_program_mode(host_program_mode),
  .persist_finish(persist_finish), .control_run(control_run), .autotuning(autotuning),
  .burnout_out(burnout_out), .persist_req(persist_req));

// ===== verif/temp_loop_operation_data_tb.sv
// Self-checking bench of the two-loop operation-data exchange.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: value mismatch", $time); end end

module temp_loop_operation_data_tb;
  import temp_loop_pkg::*;
  // ---------------------------------------------------------------
  // Signals and reference state
  // ---------------------------------------------------------------
  logic clk = 0;
  logic resetn = 0;
  logic refresh;
  logic dip_pin1_on = 0;
  logic host_program_mode = 0;
  host_out_t [1:0] host_out = '0;
  host_in_t [1:0] host_in;
  logic [1:0][15:0] pv_measured = '0;
  logic [1:0][15:0] current_measured = '0;
  logic [1:0] heater_on = '0;
  logic [1:0] persist_finish = '0;
  pid_t [1:0] host_pid = '0;
  logic [1:0] control_run, autotuning, burnout_out, persist_req;
  pid_t [1:0] working_pid;
  persist_t [1:0] persist_data;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 65314;
  host_out_t ho[2] = '{default: '0}; // Staged host variables
  host_out_t prev[2] = '{default: '0}; // Previous refresh, for edges
  pid_t exp_pid[2] = '{default: '0}; // Expected working constants
  logic [1:0] at_q = '0; // Expected autotuning
  logic [1:0] done_q = '0; // Expected persist done

  always #2 clk = ~clk;

  host_refresh_model #(.GAP(5)) host_u (.clk(clk), .resetn(resetn), .refresh(refresh));

  // Autotune engine idle: no finish pulse, so only commands move autotuning
  temp_loop_operation_data #(.PV_LOW(-16'sd2000), .PV_HIGH(16'sd13000)) dut_u (
    .clk(clk), .resetn(resetn), .refresh(refresh), .host_out(host_out), .host_in(host_in),
    .pv_measured(pv_measured), .current_measured(current_measured), .heater_on(heater_on),
    .tune_finish(2'b00), .tuned_pid('0), .host_pid(host_pid), .dip_pin1_on(dip_pin1_on),
    .host_program_mode(host_program_mode), .persist_finish(persist_finish),
    .control_run(control_run), .autotuning(autotuning), .burnout_out(burnout_out),
    .working_pid(working_pid), .persist_req(persist_req), .persist_data(persist_data));

  // ---------------------------------------------------------------
  // One host cycle: stage, wait for refresh, update model, compare
  // ---------------------------------------------------------------
  task automatic xfer(input bit rnd);
    logic [15:0] thr;
    logic flt;
    logic ovr;
    logic run;
    int p;
    @(posedge clk);
    if (rnd) begin
      dip_pin1_on <= 1'($random(seed));
      host_program_mode <= 1'($random(seed));
      for (int l = 0; l < 2; l++) begin
        ho[l].setpoint_config = 16'($random(seed));
        thr = 16'($random(seed) & 'h3ff);
        ho[l].burnout_threshold_config = (thr < 256) ? 16'h0000 : (thr < 512) ? 16'h01f4 : thr;
        {ho[l].autotune_begin_request, ho[l].autotune_abort_request,
          ho[l].control_halt_request, ho[l].pid_reload_request} = 4'($random(seed));
        pv_measured[l] <= 16'($random(seed) % 9500 + 6500);
        current_measured[l] <= 16'($random(seed) & 'h3ff);
        heater_on[l] <= 1'($random(seed));
        host_pid[l] <= {$random(seed), 16'($random(seed))};
      end
    end
    host_out <= {ho[1], ho[0]};
    @(posedge clk);
    while (refresh !== 1'b1) @(posedge clk);
    for (int l = 0; l < 2; l++) begin
      // Abort wins only while tuning; otherwise a begin edge starts it
      if (ho[l].autotune_abort_request && !prev[l].autotune_abort_request && at_q[l]) begin
        at_q[l] = 1'b0;
      end else if (ho[l].autotune_begin_request && !prev[l].autotune_begin_request) begin
        at_q[l] = 1'b1;
      end
      if (ho[l].pid_reload_request && !prev[l].pid_reload_request) exp_pid[l] = host_pid[l];
      prev[l] = ho[l];
    end
    @(posedge clk);
    #1;
    for (int l = 0; l < 2; l++) begin
      p = $signed(pv_measured[l]);
      flt = p > 13000 || p < -2000;
      ovr = current_measured[l] > 16'd550;
      thr = ho[l].burnout_threshold_config;
      // Halt masked by switch and program mode means the loop runs
      run = (!dip_pin1_on && host_program_mode) || !ho[l].control_halt_request;
      `CHK(host_in[l].process_value_monitor, flt ? 16'hcccc : pv_measured[l])
      `CHK(host_in[l].loop_status_word[14], flt)
      `CHK(host_in[l].heater_current_monitor, ovr ? 16'hcccc : current_measured[l])
      `CHK(host_in[l].loop_status_word[13], ovr)
      `CHK(host_in[l].setpoint_monitor, ho[l].setpoint_config)
      `CHK(host_in[l].burnout_threshold_monitor, thr)
      `CHK(burnout_out[l], thr == 16'h01f4 || (thr != 0 && heater_on[l] && !ovr && current_measured[l] <= thr))
      `CHK(autotuning[l], at_q[l])
      `CHK(control_run[l], run)
      `CHK(host_in[l].loop_status_word[3], at_q[l])
      `CHK(host_in[l].loop_status_word[4], run)
      `CHK(host_in[l].loop_status_word[8], !run)
      `CHK(working_pid[l], exp_pid[l])
      if (!ho[l].settings_persist_request) `CHK(host_in[l].loop_status_word[15], done_q[l])
    end
  endtask : xfer

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Watchdog: the run needs well under 2000 cycles
  initial begin
    #20000;
    fail_count++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK(host_in, '0)
    `CHK(control_run, 2'b00)
    `CHK(persist_req, 2'b00)
    repeat (60) xfer(1'b1);
    // Persist on loop 0; loop 1 must stay idle
    ho[0] = '0;
    ho[1] = '0;
    ho[0].setpoint_config = 16'h0123;
    xfer(1'b0);
    ho[0].setpoint_config = 16'h0456;
    ho[0].settings_persist_request = 1'b1;
    xfer(1'b0);
    `CHK(persist_req, 2'b01)
    `CHK(persist_data[0].setpoint, 16'h0123)
    `CHK(persist_data[0].pid, exp_pid[0])
    `CHK(persist_data[0].burnout_threshold, 16'h0000)
    // A second edge during the write is dropped
    ho[0].settings_persist_request = 1'b0;
    xfer(1'b0);
    ho[0].settings_persist_request = 1'b1;
    xfer(1'b0);
    `CHK(persist_data[0].setpoint, 16'h0123)
    @(posedge clk);
    persist_finish <= 2'b01;
    @(posedge clk);
    persist_finish <= 2'b00;
    @(posedge clk);
    #1;
    `CHK(persist_req[0], 1'b0)
    done_q[0] = 1'b1;
    ho[0].settings_persist_request = 1'b0;
    xfer(1'b0);
    test_done();
  end
endmodule : temp_loop_operation_data_tb
